// ---- logic/eepws_pkg.sv ----
/*
  Constants and types for the write-protection and status block of a
  small serial EEPROM. Assumes the clock runs at 20 MHz.
*/
`default_nettype none
package eepws_pkg;
  // instruction bytes, bit 3 is don't-care or the ninth address bit
  localparam logic [7:0] OP_MASK = 8'hF7;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_LATCH_CLR = 8'h04;
  localparam logic [7:0] OP_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_STAT_RD = 8'h05;
  localparam logic [7:0] OP_STAT_WR = 8'h01;
  localparam int OP_A8_POS = 3;
  // status byte field positions
  localparam int ST_WIP = 0;
  localparam int ST_WEL = 1;
  localparam int ST_BP_LO = 2;
  localparam int ST_BP_HI = 3;
  localparam logic [1:0] BP_RESET = 2'h0;
  // array size and protected range limits
  localparam int ADDR_W = 9;
  localparam logic [9:0] MEM_BYTES = 10'h200;
  localparam logic [8:0] QUARTER_BASE = 9'(MEM_BYTES - MEM_BYTES / 4);
  localparam logic [8:0] HALF_BASE = 9'(MEM_BYTES / 2);
  // self-timed write cycle length in clocks
  localparam int WR_CYCLES_DEF = 5000;
  localparam int TMR_W = 20;
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef enum {
    ST_IDLE, ST_CMD, ST_ADDR, ST_DATA, ST_SET, ST_CLR,
    ST_SR_IN, ST_SR_DONE, ST_SR_OUT, ST_SKIP
  } eepws_state_type;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic wp_n;
  } eepws_pins_type;

  typedef struct packed {
    logic start;
    logic [ADDR_W-1:0] addr;
  } eepws_arr_wr_type;

  typedef struct packed {
    logic stb;
    logic [7:0] data;
  } eepws_byte_type;
endpackage
`default_nettype wire

// ---- logic/eepws_core.sv ----
/*
  SPI client front end holding the write enable latch, the status byte,
  block protection and start of the self-timed write cycle.
  Assumes all pins are asynchronous to clock and that the array and its
  page buffer sit outside, fed by the byte strobes and the start pulse.
*/
// Notes on behaviour
// - no internal write completes unless the latch was set beforehand
// - set-latch command sets the latch, clear-latch command clears it
// - latch clears at reset, after clear, status or array write, wp low
// - status read is served at any time, even during a write cycle
// - status byte: bp_hi bit3, bp_lo bit2, latch bit1, busy bit0
// - busy flag is 1 while a write cycle runs, writes to it ignored
// - latch flag reads 1 when writes allowed, 0 when prohibited
// - latch commands work whatever the status protection
// - block-protect bits change only through the status write
// - protect pair: 00 none, 01 upper quarter, 10 upper half, 11 all
// - protected ranges are the upper quarter, upper half or all
// - wp low or latch clear refuses all writes; else unprotected only
// - write cycle starts only on deselect after a whole byte count
// - array access during a write cycle is ignored
// - after reset: standby, latch clear, data output not driven
// - a falling chip select is needed before any command is taken
// - set-latch is 0000x110, clear-latch is 0000x100
// - latch sets only on deselect right after the eighth bit
// - all bytes move most significant bit first
`default_nettype none
module eepws_core #(
  parameter int WR_CYCLES = eepws_pkg::WR_CYCLES_DEF
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // serial link pins
  input wire logic spi_cs_n,
  input wire logic spi_sck,
  input wire logic spi_si,
  output logic spi_so,
  output logic spi_so_oe,
  // write-protect pin
  input wire logic wp_n,
  // array side
  output var eepws_pkg::eepws_byte_type arr_byte,
  output var eepws_pkg::eepws_arr_wr_type arr_wr,
  // status view
  output logic [7:0] protection_status
);

  eepws_pkg::eepws_pins_type pins_m_q, pins_s_q, pins_p_q;
  eepws_pkg::eepws_state_type state_q;
  logic armed_q, write_latch_flag_q, write_in_progress_flag_q;
  logic [1:0] bp_q, bp_new_q;
  logic kind_stat_q, got_byte_q, so_q;
  logic [2:0] bit_q;
  logic [7:0] sh_q, out_q;
  logic [eepws_pkg::ADDR_W-1:0] addr_q;
  logic [eepws_pkg::TMR_W-1:0] tmr_q;
  logic cs_fall, cs_rise, sck_rise, sck_fall, wp_low;
  logic [7:0] sh_d, op;
  logic set_ev, clr_ev, sr_go, arr_go, cyc_end;
  logic arr_ok, sr_ok;

  // protection of one address under a block-protect pair
  function automatic logic prot_hit(
    input logic [eepws_pkg::ADDR_W-1:0] a,
    input logic [1:0] bp
  );
    case (bp)
      2'h1: prot_hit = (a >= eepws_pkg::QUARTER_BASE);
      2'h2: prot_hit = (a >= eepws_pkg::HALF_BASE);
      2'h3: prot_hit = 1'b1;
      default: prot_hit = 1'b0;
    endcase
  endfunction

  // two-flop synchroniser, then a third stage for edges
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pins_m_q <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, wp_n: 1'b0};
      pins_s_q <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, wp_n: 1'b0};
      pins_p_q <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, wp_n: 1'b0};
    end
    else
    begin
      pins_m_q <= '{cs_n: spi_cs_n, sck: spi_sck, si: spi_si, wp_n: wp_n};
      pins_s_q <= pins_m_q;
      pins_p_q <= pins_s_q;
    end
  end

  // edges seen on the clean copies only
  assign cs_fall = pins_p_q.cs_n & ~pins_s_q.cs_n;
  assign cs_rise = ~pins_p_q.cs_n & pins_s_q.cs_n;
  assign sck_rise = ~pins_s_q.cs_n & ~pins_p_q.sck & pins_s_q.sck;
  assign sck_fall = ~pins_s_q.cs_n & pins_p_q.sck & ~pins_s_q.sck;
  assign wp_low = ~pins_s_q.wp_n;
  assign sh_d = {sh_q[6:0], pins_s_q.si};
  assign op = sh_d & eepws_pkg::OP_MASK;

  // write permission matrix for status and array
  assign sr_ok = ~wp_low & write_latch_flag_q;
  assign arr_ok = sr_ok & ~prot_hit(addr_q, bp_q);

  // deselect events; only a whole byte count qualifies
  assign set_ev = cs_rise && state_q == eepws_pkg::ST_SET;
  assign clr_ev = cs_rise && state_q == eepws_pkg::ST_CLR;
  assign sr_go = cs_rise && state_q == eepws_pkg::ST_SR_DONE
    && sr_ok;
  assign arr_go = cs_rise && state_q == eepws_pkg::ST_DATA
    && got_byte_q && bit_q == 3'h0 && arr_ok;
  assign cyc_end = write_in_progress_flag_q && tmr_q == '0;

  // bit capture and command sequencing
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= eepws_pkg::ST_IDLE;
      armed_q <= 1'b0;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      addr_q <= '0;
      got_byte_q <= 1'b0;
    end
    else if (cs_fall)
    begin
      armed_q <= 1'b1;
      state_q <= eepws_pkg::ST_CMD;
      bit_q <= 3'h0;
      got_byte_q <= 1'b0;
    end
    else if (pins_s_q.cs_n)
    begin
      state_q <= eepws_pkg::ST_IDLE;
    end
    else if (sck_rise && armed_q)
    begin
      sh_q <= sh_d;
      bit_q <= bit_q + 3'h1;
      case (state_q)
        eepws_pkg::ST_CMD:
        begin
          if (bit_q == eepws_pkg::LAST_BIT)
          begin
            addr_q[8] <= sh_d[eepws_pkg::OP_A8_POS];
            // busy device answers only the status read
            if (op == eepws_pkg::OP_STAT_RD)
              state_q <= eepws_pkg::ST_SR_OUT;
            else if (write_in_progress_flag_q)
              state_q <= eepws_pkg::ST_SKIP;
            else if (sh_d[7:4] != 4'h0)
              state_q <= eepws_pkg::ST_SKIP;
            else if (op == eepws_pkg::OP_LATCH_SET)
              state_q <= eepws_pkg::ST_SET;
            else if (op == eepws_pkg::OP_LATCH_CLR)
              state_q <= eepws_pkg::ST_CLR;
            else if (op == eepws_pkg::OP_STAT_WR)
              state_q <= eepws_pkg::ST_SR_IN;
            else if (op == eepws_pkg::OP_WRITE)
              state_q <= eepws_pkg::ST_ADDR;
            else
              state_q <= eepws_pkg::ST_SKIP; // reads served elsewhere
          end
        end
        eepws_pkg::ST_ADDR:
        begin
          if (bit_q == eepws_pkg::LAST_BIT)
          begin
            addr_q[7:0] <= sh_d;
            state_q <= eepws_pkg::ST_DATA;
          end
        end
        eepws_pkg::ST_DATA:
        begin
          if (bit_q == eepws_pkg::LAST_BIT)
            got_byte_q <= 1'b1;
        end
        eepws_pkg::ST_SR_IN:
        begin
          if (bit_q == eepws_pkg::LAST_BIT)
            state_q <= eepws_pkg::ST_SR_DONE;
        end
        eepws_pkg::ST_SR_OUT, eepws_pkg::ST_SKIP:
          state_q <= state_q;
        // extra clocks after a latch or status byte void the command
        eepws_pkg::ST_SET, eepws_pkg::ST_CLR, eepws_pkg::ST_SR_DONE:
          state_q <= eepws_pkg::ST_SKIP;
        default:
          state_q <= eepws_pkg::ST_SKIP;
      endcase
    end
  end

  // data bytes handed to the page buffer as they complete
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      arr_byte <= '0;
    else
    begin
      arr_byte.stb <= sck_rise && armed_q && bit_q == eepws_pkg::LAST_BIT
        && state_q == eepws_pkg::ST_DATA;
      if (sck_rise && bit_q == eepws_pkg::LAST_BIT)
        arr_byte.data <= sh_d;
    end
  end

  // write enable latch; a low wp pin beats a set
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      write_latch_flag_q <= 1'b0;
    else if (wp_low)
      write_latch_flag_q <= 1'b0;
    else if (clr_ev || cyc_end)
      write_latch_flag_q <= 1'b0;
    else if (set_ev)
      write_latch_flag_q <= 1'b1;
  end

  // self-timed cycle; the pin only gates the start, never aborts
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      write_in_progress_flag_q <= 1'b0;
      tmr_q <= '0;
      kind_stat_q <= 1'b0;
      bp_new_q <= eepws_pkg::BP_RESET;
    end
    else if (sr_go || arr_go)
    begin
      write_in_progress_flag_q <= 1'b1;
      tmr_q <= eepws_pkg::TMR_W'(WR_CYCLES - 1);
      kind_stat_q <= sr_go;
      bp_new_q <= sh_q[eepws_pkg::ST_BP_HI:eepws_pkg::ST_BP_LO];
    end
    else if (cyc_end)
      write_in_progress_flag_q <= 1'b0;
    else if (write_in_progress_flag_q)
      tmr_q <= tmr_q - eepws_pkg::TMR_W'(1);
  end

  // block-protect pair, loaded at the end of a status cycle
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      bp_q <= eepws_pkg::BP_RESET; // stands in for stored value
    else if (cyc_end && kind_stat_q)
      bp_q <= bp_new_q;
  end

  // array start pulse with the page address
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      arr_wr <= '0;
    else
    begin
      arr_wr.start <= arr_go;
      if (arr_go)
        arr_wr.addr <= addr_q;
    end
  end

  // live status byte, high nibble reads zero
  assign protection_status = {4'h0, bp_q, write_latch_flag_q,
    write_in_progress_flag_q};

  // status shifted out after each falling clock, reloaded per byte
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      so_q <= 1'b0;
      out_q <= 8'h00;
    end
    else if (state_q != eepws_pkg::ST_SR_OUT)
      out_q <= 8'h00;
    else if (sck_fall)
    begin
      if (bit_q == 3'h0)
      begin
        so_q <= protection_status[7];
        out_q <= {protection_status[6:0], 1'b0};
      end
      else
      begin
        so_q <= out_q[7];
        out_q <= {out_q[6:0], 1'b0};
      end
    end
  end

  // output driven only while answering a status read
  assign spi_so = so_q;
  assign spi_so_oe = (state_q == eepws_pkg::ST_SR_OUT)
    && !pins_s_q.cs_n;

  // status cycle: start, busy held, then bits stored and latch cleared
  sequence s_sr_start;
    sr_go;
  endsequence
  sequence s_busy_hold;
    write_in_progress_flag_q [*8];
  endsequence

  AST_START_NEEDS_LATCH: assert property (
    @(posedge clock) disable iff (!rst_n)
    (sr_go || arr_go) |-> write_latch_flag_q && !wp_low)
    else $error("write cycle started with latch clear");

  AST_LATCH_SET: assert property (
    @(posedge clock) disable iff (!rst_n)
    set_ev && !wp_low |=> write_latch_flag_q)
    else $error("latch not set after set command");

  AST_WP_CLEARS: assert property (
    @(posedge clock) disable iff (!rst_n)
    wp_low |=> !write_latch_flag_q)
    else $error("latch survived wp low");

  AST_STATUS_LAYOUT: assert property (
    @(posedge clock) disable iff (!rst_n)
    protection_status[7:4] == 4'h0
    && protection_status[3:2] == bp_q)
    else $error("status byte layout wrong");

  AST_BUSY_HOLDS: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_sr_start |=> s_busy_hold)
    else $error("busy flag dropped early");

  AST_END_CLEARS_LATCH: assert property (
    @(posedge clock) disable iff (!rst_n)
    $fell(write_in_progress_flag_q) |-> !write_latch_flag_q)
    else $error("latch still set after write cycle");

  AST_BP_ONLY_STATUS: assert property (
    @(posedge clock) disable iff (!rst_n)
    $changed(bp_q) |-> $past(cyc_end) && $past(kind_stat_q))
    else $error("protect bits changed outside status write");

  AST_NO_START_BUSY: assert property (
    @(posedge clock) disable iff (!rst_n)
    write_in_progress_flag_q |-> !arr_go && !sr_go)
    else $error("new write cycle during busy");

  AST_SO_IDLE: assert property (
    @(posedge clock) disable iff (!rst_n)
    pins_s_q.cs_n |-> !spi_so_oe)
    else $error("data output driven while deselected");

  AST_PROT_REFUSED: assert property (
    @(posedge clock) disable iff (!rst_n)
    arr_go |-> !prot_hit(addr_q, bp_q) ##1 arr_wr.start)
    else $error("protected address written");

endmodule // eepws_core
`default_nettype wire

// ---- sim/eepws_host.sv ----
/*
  SPI host model for the status block, one frame per call.
  Assumes it is paced by the block's clock; sck is 400 ns a bit.
*/
`default_nettype none
module eepws_host (
  // pacing clock
  input wire logic clock,
  // serial link
  output logic spi_cs_n,
  output logic spi_sck,
  input wire logic spi_so,
  input wire logic spi_so_oe,
  output logic spi_si
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle: deselected, sck still
  initial
  begin
    spi_cs_n = 1'b1;
    spi_sck = 1'b0;
    spi_si = 1'b0;
  end
  // whole clocks, then step clear of the edge
  task automatic ticks(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // n bytes out, last byte seen on so comes back
  task automatic xfer(input logic [7:0] b0, input logic [7:0] b1,
      input logic [7:0] b2, input int n, output logic [7:0] rx);
    logic [7:0] tx [3];
    tx[0] = b0;
    tx[1] = b1;
    tx[2] = b2;
    rx = 8'h00;
    spi_cs_n = 1'b0;
    ticks(4);
    for (int i = 0; i < n; i++)
    begin
      for (int b = 7; b >= 0; b--)
      begin
        spi_si = tx[i][b];
        ticks(4);
        spi_sck = 1'b1;
        ticks(3);
        // undriven so must not pass for data
        rx = {rx[6:0], spi_so_oe ? spi_so : 1'bx};
        ticks(1);
        spi_sck = 1'b0;
      end
    end
    ticks(4);
    spi_cs_n = 1'b1;
    spi_si = ~spi_si; // no stale level between frames
    ticks(8);
  endtask
endmodule // eepws_host
`default_nettype wire

// ---- sim/testbench.sv ----
/*
  Self-checking bench for the write-protection and status block.
  Assumes eepws_host as the far side and the eepws_pkg package.
*/
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int WR_CYC = 400;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic wp_n = 1'b1;
  logic spi_cs_n, spi_sck, spi_si, spi_so, spi_so_oe;
  eepws_pkg::eepws_byte_type arr_byte;
  eepws_pkg::eepws_arr_wr_type arr_wr;
  logic [7:0] protection_status;
  logic [7:0] rx;
  logic [8:0] addrs [6] = '{9'h000, 9'h0FF, 9'h100, 9'h17F, 9'h180,
      9'h1FF};
  int failures = 0;
  int comparisons = 0;
  int starts = 0;
  int bytes_seen = 0;
  int cycles = 0;

  always #25 clock = ~clock;

  eepws_core #(.WR_CYCLES(WR_CYC)) dut (
    .clock(clock), .rst_n(rst_n), .spi_cs_n(spi_cs_n),
    .spi_sck(spi_sck), .spi_si(spi_si), .spi_so(spi_so),
    .spi_so_oe(spi_so_oe), .wp_n(wp_n), .arr_byte(arr_byte),
    .arr_wr(arr_wr), .protection_status(protection_status)
  );
  eepws_host host (
    .clock(clock), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
    .spi_so(spi_so), .spi_so_oe(spi_so_oe), .spi_si(spi_si)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // one-byte command frame
  task automatic cmd(input logic [7:0] op);
    host.xfer(op, 8'h00, 8'h00, 1, rx);
  endtask

  // allowed only under the protect code in use
  function automatic logic ok_addr(input logic [1:0] bp,
      input logic [8:0] a);
    case (bp)
      2'h0: return 1'b1;
      2'h1: return a < 9'h180;
      2'h2: return a < 9'h100;
      default: return 1'b0;
    endcase
  endfunction

  // start counter and a ceiling, the run needs about 25000 cycles
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (arr_wr.start === 1'b1)
      starts <= starts + 1;
    // byte strobes handed to the page buffer
    if (arr_byte.stb === 1'b1)
      bytes_seen <= bytes_seen + 1;
    if (cycles == 60000)
    begin
      failures = failures + 1;
      tally_and_finish();
    end
  end

  initial
  begin
    int n0, b0;
    logic ok;
    logic [7:0] dat;
    repeat (12) @(posedge clock);
    #1;
    check(16'(protection_status), 16'h0000);
    check(16'(spi_so_oe), 16'h0000);
    rst_n = 1'b1;
    host.ticks(6);
    host.xfer(8'h01, 8'h0C, 8'h00, 2, rx);
    check(16'(protection_status), 16'h0000);
    // both values of the don't-care bit
    for (int x = 0; x < 2; x++)
    begin
      cmd({4'h0, x[0], 3'h6});
      check(16'(protection_status), 16'h0002);
      cmd({4'h0, x[0], 3'h4});
      check(16'(protection_status), 16'h0000);
    end
    // nonzero upper nibble is no latch command
    cmd(8'h16);
    check(16'(protection_status), 16'h0000);
    // set command run on into a write without deselect
    host.xfer(8'h06, 8'h02, 8'h00, 3, rx);
    check(16'(protection_status), 16'h0000);
    check(16'(starts), 16'h0000);
    check(16'(bytes_seen), 16'h0000);
    // status write; a 1 in the busy bit must not stick
    cmd(8'h06);
    host.xfer(8'h01, 8'h0D, 8'h00, 2, rx);
    check(16'(protection_status), 16'h0003);
    host.xfer(8'h05, 8'h00, 8'h00, 2, rx);
    check(16'(rx), 16'h0003);
    host.ticks(WR_CYC);
    check(16'(protection_status), 16'h000C);
    // pin low drops the latch and beats a later set
    cmd(8'h06);
    wp_n = 1'b0;
    host.ticks(4);
    check(16'(protection_status), 16'h000C);
    cmd(8'h06);
    host.xfer(8'h01, 8'h00, 8'h00, 2, rx);
    check(16'(protection_status), 16'h000C);
    wp_n = 1'b1;
    // every protect code against boundary addresses
    for (int p = 0; p < 4; p++)
    begin
      cmd(8'h06);
      host.xfer(8'h01, {4'h0, p[1:0], 2'h0}, 8'h00, 2, rx);
      host.ticks(WR_CYC);
      check(16'(protection_status), {12'h000, p[1:0], 2'h0});
      for (int k = 0; k < 6; k++)
      begin
        ok = ok_addr(p[1:0], addrs[k]);
        dat = 8'h96 + 8'(k);
        n0 = starts;
        b0 = bytes_seen;
        cmd(8'h06);
        host.xfer({4'h0, addrs[k][8], 3'h2}, addrs[k][7:0], dat, 3, rx);
        check(16'(starts - n0), {15'h0000, ok});
        check(16'(bytes_seen - b0), 16'h0001);
        if (ok)
        begin
          check(16'(arr_wr.addr), 16'(addrs[k]));
          check(16'(arr_byte.data), 16'(dat));
          check(16'(protection_status[0]), 16'h0001);
          host.xfer(8'h02, 8'h20, 8'h33, 3, rx);
          check(16'(starts - n0), 16'h0001);
          check(16'(bytes_seen - b0), 16'h0001);
        end
        host.ticks(WR_CYC);
        // a refused write is not executed, so the latch stays set
        check(16'(protection_status), {12'h000, p[1:0], ~ok, 1'b0});
        cmd(8'h04);
      end
    end
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
